// ### bwau_defs.svh
// Constants of the sixteen-bit binary arithmetic unit
`ifndef BWAU_DEFS_SVH
`define BWAU_DEFS_SVH

// ************************************************************
// Register bus
// ************************************************************
`define BWAU_AW          4
`define BWAU_DW          16
`define BWAU_OFS_AUG     4'h0
`define BWAU_OFS_ADD     4'h1
`define BWAU_OFS_CMD     4'h2
`define BWAU_OFS_PTR     4'h3
`define BWAU_OFS_RES_LO  4'h4
`define BWAU_OFS_RES_HI  4'h5
`define BWAU_OFS_STAT    4'h6
`define BWAU_OFS_IRQ_ST  4'h7
`define BWAU_OFS_IRQ_MSK 4'h8

// ************************************************************
// Values and layouts
// ************************************************************
`define BWAU_RST_WORD    16'h0000
`define BWAU_CMD_W       5
`define BWAU_STAT_W      5
`define BWAU_IRQ_W       4
`define BWAU_IRQ_DONE    0
`define BWAU_IRQ_ERR     1
`define BWAU_IRQ_OVF     2
`define BWAU_IRQ_UNF     3
`define BWAU_SMAX        18'sh07FFF
`define BWAU_SMIN        -18'sh08000
`define BWAU_AREA_LAST   16'h1999
`define BWAU_BCD_MAX     4'h9

`endif

// ### bwau_pkg.sv
// Types of the sixteen-bit binary arithmetic unit
package bwau_pkg;

   typedef enum logic [2:0] {
      BWAU_NOP_OP              = 3'h0,
      BWAU_BINARY_ADD_OP       = 3'h1,
      BWAU_BINARY_SUBTRACT_OP  = 3'h2,
      BWAU_BINARY_MULTIPLY_OP  = 3'h3,
      BWAU_SET_CARRY_OP        = 3'h4,
      BWAU_CLEAR_CARRY_OP      = 3'h5
   } bwau_op_t;

   // Command word: indirect pointer use, execution condition, operation
   typedef struct packed {
      logic     ind;
      logic     cond;
      bwau_op_t op;
   } bwau_cmd_t;

   // Special status word, fixed bit positions
   typedef struct packed {
      logic operand_error_flag;
      logic signed_underflow_flag;
      logic signed_overflow_flag;
      logic zero_flag;
      logic carry_flag;
   } bwau_stat_t;

endpackage : bwau_pkg

// ### bwau_unit.sv
// Sixteen-bit binary add, subtract and multiply datapath with register port
//
// Contract
// RULE_01: Condition false means the operation is skipped and nothing is written.
// RULE_02: Add sums augend, addend and carry; low sixteen bits go to result.
// RULE_03: Add sets carry when unsigned sum exceeds FFFF, else clears it.
// RULE_04: Subtract takes subtrahend and carry from minuend into the result word.
// RULE_05: Negative difference sets carry; result holds its two's complement.
// RULE_06: Subtract carry set exactly when minuend below subtrahend plus carry.
// RULE_07: Add and subtract flag signed overflow above 7FFF.
// RULE_08: Add and subtract flag signed underflow below 8000.
// RULE_09: Add, subtract and multiply set zero flag on a zero result.
// RULE_10: Bad indirect pointer, not decimal or past the area, raises operand error.
// RULE_11: Carry is input and output; separate set and clear operations exist.
// RULE_12: Program clears carry beforehand and consumes it before it changes.
// RULE_13: Signed values are sixteen-bit two's complement, sign in top bit.
// RULE_14: Overflow, underflow and carry live in fixed status bits.
// RULE_15: Multiply is unsigned; low word to first result, high word next.
// RULE_16: Unsigned multiply reports only the error and zero flags.
// RULE_17: Program keeps both multiply result words in one data area.
// RULE_18: Skipped or errored operations leave results and carry unchanged.
//
// Local design decisions: the address-and-strobe port and the address map.
`include "bwau_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module bwau_unit
   import bwau_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   input  wire logic [`BWAU_AW-1:0]   addr,
   input  wire logic [`BWAU_DW-1:0]   wdata,
   input  wire logic                  wr,
   input  wire logic                  rd,
   output var  logic [`BWAU_DW-1:0]   rdata_q,
   output var  logic                  irq_q
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [`BWAU_DW-1:0]    augend_word_q;
   logic [`BWAU_DW-1:0]    addend_word_q;
   logic [`BWAU_DW-1:0]    ptr_q;
   logic [`BWAU_DW-1:0]    res_lo_q;
   logic [`BWAU_DW-1:0]    res_hi_q;
   bwau_stat_t             stat_q;
   logic [`BWAU_IRQ_W-1:0] ist_q;
   logic [`BWAU_IRQ_W-1:0] msk_q;
   logic [`BWAU_IRQ_W-1:0] ev_d;
   bwau_cmd_t              cmd_d;
   logic                   go_d;
   logic                   run_d;
   logic                   err_d;
   logic                   ok_d;
   logic [16:0]            add_sum_d;
   logic [16:0]            sub_dif_d;
   logic signed [17:0]     s_add_d;
   logic signed [17:0]     s_sub_d;
   logic [31:0]            prod_d;
   logic                   is_add_d;
   logic                   is_sub_d;
   logic                   is_mul_d;

   // ************************************************************
   // Functions
   // ************************************************************
   // Sign extension of a two's-complement word
   function automatic logic signed [17:0] sext(input logic [15:0] w);
      sext = $signed({{2{w[15]}}, w}); // see RULE_13
   endfunction : sext

   // Pointer must be decimal and inside the data area
   function automatic logic ptr_valid(input logic [15:0] p);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (p[i*4 +: 4] > `BWAU_BCD_MAX) begin
            ok = 1'b0;
         end
      end
      // Valid decimal orders like binary, so a plain compare works
      ptr_valid = ok && (p <= `BWAU_AREA_LAST); // see RULE_10
   endfunction : ptr_valid

   // ************************************************************
   // Datapath
   // ************************************************************
   always_comb begin
      go_d      = wr && (addr == `BWAU_OFS_CMD);
      cmd_d     = bwau_cmd_t'(wdata[`BWAU_CMD_W-1:0]);
      run_d     = go_d && cmd_d.cond; // see RULE_01
      ok_d      = ptr_valid(ptr_q);
      err_d     = run_d && cmd_d.ind && !ok_d; // see RULE_10
      is_add_d  = cmd_d.op == BWAU_BINARY_ADD_OP;
      is_sub_d  = cmd_d.op == BWAU_BINARY_SUBTRACT_OP;
      is_mul_d  = cmd_d.op == BWAU_BINARY_MULTIPLY_OP;
      // Carry enters as the low-order term
      add_sum_d = {1'b0, augend_word_q} + {1'b0, addend_word_q}
                  + {16'h0000, stat_q.carry_flag}; // see RULE_02
      // Borrow lands in bit 16, low bits are the two's complement
      sub_dif_d = {1'b0, augend_word_q} - {1'b0, addend_word_q}
                  - {16'h0000, stat_q.carry_flag}; // see RULE_04
      s_add_d   = sext(augend_word_q) + sext(addend_word_q)
                  + $signed({17'h00000, stat_q.carry_flag});
      s_sub_d   = sext(augend_word_q) - sext(addend_word_q)
                  - $signed({17'h00000, stat_q.carry_flag});
      prod_d    = augend_word_q * addend_word_q; // see RULE_15
   end

   // ************************************************************
   // Operand and pointer registers
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         augend_word_q <= `BWAU_RST_WORD;
         addend_word_q <= `BWAU_RST_WORD;
         ptr_q         <= `BWAU_RST_WORD;
      end else if (wr) begin
         if (addr == `BWAU_OFS_AUG) begin
            augend_word_q <= wdata;
         end
         if (addr == `BWAU_OFS_ADD) begin
            addend_word_q <= wdata;
         end
         if (addr == `BWAU_OFS_PTR) begin
            ptr_q <= wdata;
         end
      end
   end

   // ************************************************************
   // Result words
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         res_lo_q <= `BWAU_RST_WORD;
         res_hi_q <= `BWAU_RST_WORD;
      end else if (run_d && !err_d) begin // see RULE_18
         if (is_add_d) begin
            res_lo_q <= add_sum_d[15:0]; // see RULE_02
         end
         if (is_sub_d) begin
            res_lo_q <= sub_dif_d[15:0]; // see RULE_05
         end
         if (is_mul_d) begin
            res_lo_q <= prod_d[15:0]; // see RULE_15
            res_hi_q <= prod_d[31:16];
         end
      end
   end

   // ************************************************************
   // Status flags
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stat_q <= '0;
      end else if (run_d) begin
         stat_q.operand_error_flag <= err_d; // see RULE_10
         if (!err_d) begin
            unique case (cmd_d.op)
               BWAU_BINARY_ADD_OP: begin
                  stat_q.carry_flag            <= add_sum_d[16]; // see RULE_03
                  stat_q.zero_flag             <= add_sum_d[15:0] == 16'h0000; // see RULE_09
                  stat_q.signed_overflow_flag  <= s_add_d > `BWAU_SMAX; // see RULE_07
                  stat_q.signed_underflow_flag <= s_add_d < `BWAU_SMIN; // see RULE_08
               end
               BWAU_BINARY_SUBTRACT_OP: begin
                  stat_q.carry_flag            <= sub_dif_d[16]; // see RULE_06
                  stat_q.zero_flag             <= sub_dif_d[15:0] == 16'h0000; // see RULE_09
                  stat_q.signed_overflow_flag  <= s_sub_d > `BWAU_SMAX; // see RULE_07
                  stat_q.signed_underflow_flag <= s_sub_d < `BWAU_SMIN; // see RULE_08
               end
               BWAU_BINARY_MULTIPLY_OP: begin
                  // Only zero and error move here
                  stat_q.zero_flag <= prod_d == 32'h0000_0000; // see RULE_16
               end
               BWAU_SET_CARRY_OP: begin
                  stat_q.carry_flag <= 1'b1; // see RULE_11
               end
               BWAU_CLEAR_CARRY_OP: begin
                  stat_q.carry_flag <= 1'b0; // see RULE_11
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Interrupt status, mask and output
   // ************************************************************
   always_comb begin
      ev_d                 = '0;
      ev_d[`BWAU_IRQ_DONE] = run_d && !err_d;
      ev_d[`BWAU_IRQ_ERR]  = err_d;
      ev_d[`BWAU_IRQ_OVF]  = run_d && !err_d && ((is_add_d && s_add_d > `BWAU_SMAX)
                             || (is_sub_d && s_sub_d > `BWAU_SMAX));
      ev_d[`BWAU_IRQ_UNF]  = run_d && !err_d && ((is_add_d && s_add_d < `BWAU_SMIN)
                             || (is_sub_d && s_sub_d < `BWAU_SMIN));
   end

   // New events win over a write-one clear in the same cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ist_q <= '0;
      end else if (wr && addr == `BWAU_OFS_IRQ_ST) begin
         ist_q <= (ist_q & ~wdata[`BWAU_IRQ_W-1:0]) | ev_d;
      end else begin
         ist_q <= ist_q | ev_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         msk_q <= '0;
      end else if (wr && addr == `BWAU_OFS_IRQ_MSK) begin
         msk_q <= wdata[`BWAU_IRQ_W-1:0];
      end
   end

   // One cycle behind the status, kept registered for a clean output
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ist_q & msk_q);
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= `BWAU_RST_WORD;
      end else if (rd) begin
         unique case (addr)
            `BWAU_OFS_AUG:     rdata_q <= augend_word_q;
            `BWAU_OFS_ADD:     rdata_q <= addend_word_q;
            `BWAU_OFS_PTR:     rdata_q <= ptr_q;
            `BWAU_OFS_RES_LO:  rdata_q <= res_lo_q;
            `BWAU_OFS_RES_HI:  rdata_q <= res_hi_q;
            `BWAU_OFS_STAT:    rdata_q <= {11'h000, stat_q}; // see RULE_14
            `BWAU_OFS_IRQ_ST:  rdata_q <= {12'h000, ist_q};
            `BWAU_OFS_IRQ_MSK: rdata_q <= {12'h000, msk_q};
            default:           rdata_q <= `BWAU_RST_WORD;
         endcase
      end else begin
         rdata_q <= `BWAU_RST_WORD;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_skip;
      @(posedge mclk) disable iff (!rst_b)
      go_d && !cmd_d.cond |=> $stable(res_lo_q) && $stable(res_hi_q) && $stable(stat_q);
   endproperty
   a_skip: assert property (p_skip) else $error("skipped op changed state"); // see RULE_01

   property p_add;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && is_add_d |=>
         {stat_q.carry_flag, res_lo_q} ==
         $past({1'b0, augend_word_q}) + $past({1'b0, addend_word_q})
         + {16'h0000, $past(stat_q.carry_flag)};
   endproperty
   a_add: assert property (p_add) else $error("add result or carry wrong"); // see RULE_03

   property p_sub;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && is_sub_d |=>
         stat_q.carry_flag == ($past({1'b0, augend_word_q}) <
         $past({1'b0, addend_word_q}) + {16'h0000, $past(stat_q.carry_flag)})
         && res_lo_q == 16'($past(augend_word_q) - $past(addend_word_q)
         - {15'h0000, $past(stat_q.carry_flag)});
   endproperty
   a_sub: assert property (p_sub) else $error("subtract borrow or result wrong"); // see RULE_06

   property p_ovf;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && is_add_d ##1 1'b1 |->
         stat_q.signed_overflow_flag == ($past(s_add_d) > `BWAU_SMAX)
         && stat_q.signed_underflow_flag == ($past(s_add_d) < `BWAU_SMIN);
   endproperty
   a_ovf: assert property (p_ovf) else $error("signed range flags wrong"); // see RULE_07

   property p_mul;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && is_mul_d |=>
         {res_hi_q, res_lo_q} == $past(augend_word_q) * $past(addend_word_q)
         && stat_q.zero_flag == ({res_hi_q, res_lo_q} == 32'h0000_0000)
         && $stable(stat_q.carry_flag) && $stable(stat_q.signed_overflow_flag);
   endproperty
   a_mul: assert property (p_mul) else $error("multiply result or flags wrong"); // see RULE_16

   property p_zero;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && (is_add_d || is_sub_d) |=>
         stat_q.zero_flag == (res_lo_q == 16'h0000);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong"); // see RULE_09

   property p_err;
      @(posedge mclk) disable iff (!rst_b)
      run_d && cmd_d.ind && !ptr_valid(ptr_q) |=>
         stat_q.operand_error_flag && $stable(res_lo_q) && $stable(stat_q.carry_flag)
         && ist_q[`BWAU_IRQ_ERR];
   endproperty
   a_err: assert property (p_err) else $error("operand error not handled"); // see RULE_18

   property p_carry_ops;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && (cmd_d.op == BWAU_SET_CARRY_OP || cmd_d.op == BWAU_CLEAR_CARRY_OP)
         |=> stat_q.carry_flag == ($past(cmd_d.op) == BWAU_SET_CARRY_OP)
         && $stable(res_lo_q);
   endproperty
   a_carry_ops: assert property (p_carry_ops) else $error("carry set or clear wrong"); // see RULE_11

   property p_irq;
      @(posedge mclk) disable iff (!rst_b)
      ##1 1'b1 |-> irq_q == $past(|(ist_q & msk_q));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output mismatch");

   property p_rd_once;
      @(posedge mclk) disable iff (!rst_b)
      !rd |=> rdata_q == 16'h0000;
   endproperty
   a_rd_once: assert property (p_rd_once) else $error("read data outside its cycle");

   property p_sub_rng;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && is_sub_d |=>
         stat_q.signed_overflow_flag == ($past(s_sub_d) > `BWAU_SMAX)
         && stat_q.signed_underflow_flag == ($past(s_sub_d) < `BWAU_SMIN);
   endproperty
   a_sub_rng: assert property (p_sub_rng) else $error("subtract range flags wrong"); // see RULE_08

   // Two non-negative words can never fall below the signed range
   property p_pos_sum;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !err_d && is_add_d && !augend_word_q[15] && !addend_word_q[15]
         |=> !stat_q.signed_underflow_flag;
   endproperty
   a_pos_sum: assert property (p_pos_sum) else $error("underflow from positive sum"); // see RULE_13

   property p_hi_keep;
      @(posedge mclk) disable iff (!rst_b)
      run_d && (is_add_d || is_sub_d) |=> $stable(res_hi_q);
   endproperty
   a_hi_keep: assert property (p_hi_keep) else $error("add or subtract touched high word"); // see RULE_04

   property p_no_err;
      @(posedge mclk) disable iff (!rst_b)
      run_d && !cmd_d.ind |=> !stat_q.operand_error_flag;
   endproperty
   a_no_err: assert property (p_no_err) else $error("error flag without indirect operand"); // see RULE_10

   property p_ist_sticky;
      @(posedge mclk) disable iff (!rst_b)
      !(wr && addr == `BWAU_OFS_IRQ_ST) |=> (ist_q & $past(ist_q)) == $past(ist_q);
   endproperty
   a_ist_sticky: assert property (p_ist_sticky) else $error("interrupt status bit lost");

   // A written one clears its bit unless an event lands in the same cycle
   property p_ist_clr;
      @(posedge mclk) disable iff (!rst_b)
      wr && addr == `BWAU_OFS_IRQ_ST |=>
         (ist_q & $past(wdata[`BWAU_IRQ_W-1:0])) == ($past(ev_d) & $past(wdata[`BWAU_IRQ_W-1:0]));
   endproperty
   a_ist_clr: assert property (p_ist_clr) else $error("interrupt status clear wrong");

   c_add_carry: cover property (@(posedge mclk) disable iff (!rst_b)
      run_d && is_add_d && add_sum_d[16]);
   c_sub_neg: cover property (@(posedge mclk) disable iff (!rst_b)
      run_d && is_sub_d && sub_dif_d[16] && s_sub_d > `BWAU_SMAX);
   c_mul_hi: cover property (@(posedge mclk) disable iff (!rst_b)
      run_d && is_mul_d && prod_d[31:16] != 16'h0000);
   c_err: cover property (@(posedge mclk) disable iff (!rst_b) err_d);

endmodule : bwau_unit

`default_nettype wire

// ### tb_top.sv
// Self-checking testbench of the sixteen-bit binary arithmetic unit
`include "bwau_defs.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
   $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top
   import bwau_pkg::*;
;
   logic                mclk;
   logic                rst_b;
   logic [`BWAU_AW-1:0] addr;
   logic [`BWAU_DW-1:0] wdata;
   logic                wr;
   logic                rd;
   logic [`BWAU_DW-1:0] rdata_q;
   logic                irq_q;
   int                  errors;
   int                  num_checks;
   int                  seed;
   logic [31:0]         r;
   logic [15:0]         d;
   logic [15:0]         m_aug, m_add, m_ptr, m_lo, m_hi;
   logic [3:0]          m_ist, m_msk;
   bwau_stat_t          m_stat;
   logic [15:0]         c_a [8] = '{16'hA6E2, 16'h7544, 16'h8AD0, 16'hFFFF, 16'h7FFF, 16'hFFFF, 16'h0000, 16'h0000};
   logic [15:0]         c_b [8] = '{16'h80C5, 16'hC47A, 16'h0BB8, 16'h0001, 16'h0000, 16'hFFFF, 16'h1234, 16'h0001};
   bwau_op_t            c_op [8] = '{BWAU_BINARY_ADD_OP, BWAU_BINARY_SUBTRACT_OP, BWAU_BINARY_SUBTRACT_OP,
                                     BWAU_BINARY_ADD_OP, BWAU_BINARY_ADD_OP, BWAU_BINARY_MULTIPLY_OP,
                                     BWAU_BINARY_MULTIPLY_OP, BWAU_BINARY_SUBTRACT_OP};

   bwau_unit dut_u (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .addr    (addr),
      .wdata   (wdata),
      .wr      (wr),
      .rd      (rd),
      .rdata_q (rdata_q),
      .irq_q   (irq_q)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // *****************************
   // Bus tasks and expectations
   // *****************************
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : bus_wr

   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      v = rdata_q;
   endtask : bus_rd

   function automatic logic [15:0] exp_reg(input logic [3:0] a);
      case (a)
         `BWAU_OFS_AUG:     return m_aug;
         `BWAU_OFS_ADD:     return m_add;
         `BWAU_OFS_PTR:     return m_ptr;
         `BWAU_OFS_RES_LO:  return m_lo;
         `BWAU_OFS_RES_HI:  return m_hi;
         `BWAU_OFS_STAT:    return {11'h000, m_stat};
         `BWAU_OFS_IRQ_ST:  return {12'h000, m_ist};
         `BWAU_OFS_IRQ_MSK: return {12'h000, m_msk};
         default:           return 16'h0000;
      endcase
   endfunction : exp_reg

   function automatic logic ptr_ok(input logic [15:0] p);
      return (p <= `BWAU_AREA_LAST) && (p[3:0] <= `BWAU_BCD_MAX) && (p[7:4] <= `BWAU_BCD_MAX)
         && (p[11:8] <= `BWAU_BCD_MAX);
   endfunction : ptr_ok

   task automatic model_clear();
      {m_aug, m_add, m_ptr, m_lo, m_hi} = '0;
      {m_ist, m_msk} = '0;
      m_stat = '0;
   endtask : model_clear

   task automatic sweep();
      for (int i = 0; i < 16; i++) begin
         bus_rd(4'(i), d);
         `CHK(d, exp_reg(4'(i)))
      end
   endtask : sweep

   task automatic run_op(input logic [15:0] a, input logic [15:0] b, input bwau_op_t op,
                         input logic cond, input logic ind);
      int ua, ub, sa, sb, ci, s, ss;
      logic [31:0] p;
      bus_wr(`BWAU_OFS_AUG, a);
      bus_wr(`BWAU_OFS_ADD, b);
      bus_wr(`BWAU_OFS_CMD, {11'h000, ind, cond, op});
      m_aug = a;
      m_add = b;
      ua = a;
      ub = b;
      sa = $signed(a);
      sb = $signed(b);
      ci = m_stat.carry_flag;
      if (cond && ind && !ptr_ok(m_ptr)) begin
         m_stat.operand_error_flag = 1'b1;
         m_ist[`BWAU_IRQ_ERR] = 1'b1;
      end else if (cond) begin
         m_stat.operand_error_flag = 1'b0;
         m_ist[`BWAU_IRQ_DONE] = 1'b1;
         case (op)
            BWAU_BINARY_ADD_OP, BWAU_BINARY_SUBTRACT_OP: begin
               s  = (op == BWAU_BINARY_ADD_OP) ? ua + ub + ci : ua - ub - ci;
               ss = (op == BWAU_BINARY_ADD_OP) ? sa + sb + ci : sa - sb - ci;
               m_lo = s[15:0];
               m_stat.carry_flag = (op == BWAU_BINARY_ADD_OP) ? (s > 65535) : (ua < ub + ci);
               m_stat.zero_flag = (s[15:0] == 16'h0000);
               m_stat.signed_overflow_flag = (ss > 32767);
               m_stat.signed_underflow_flag = (ss < -32768);
               m_ist[`BWAU_IRQ_OVF] |= (ss > 32767);
               m_ist[`BWAU_IRQ_UNF] |= (ss < -32768);
            end
            BWAU_BINARY_MULTIPLY_OP: begin
               p = 32'(a) * 32'(b);
               m_lo = p[15:0];
               m_hi = p[31:16];
               m_stat.zero_flag = (p == 32'h0000_0000);
            end
            BWAU_SET_CARRY_OP:   m_stat.carry_flag = 1'b1;
            BWAU_CLEAR_CARRY_OP: m_stat.carry_flag = 1'b0;
            default: ;
         endcase
      end
      bus_rd(`BWAU_OFS_RES_LO, d);
      `CHK(d, m_lo)
      bus_rd(`BWAU_OFS_RES_HI, d);
      `CHK(d, m_hi)
      bus_rd(`BWAU_OFS_STAT, d);
      `CHK(d[0], m_stat.carry_flag)
      `CHK(d[1], m_stat.zero_flag)
      `CHK(d[2], m_stat.signed_overflow_flag)
      `CHK(d[3], m_stat.signed_underflow_flag)
      `CHK(d[4], m_stat.operand_error_flag)
      `CHK(d[15:5], 11'h000)
      bus_rd(`BWAU_OFS_IRQ_ST, d);
      `CHK(d[3:0], m_ist)
      `CHK(irq_q, |(m_ist & m_msk))
   endtask : run_op

   task automatic test_done();
      $display("Checks: %0d, errors: %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // *****************************
   // Main sequence
   // *****************************
   initial begin
      seed = 93180;
      errors = 0;
      num_checks = 0;
      rst_b = 1'b0;
      {wr, rd, addr, wdata} = '0;
      model_clear();
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      sweep();
      @(posedge mclk);
      #1;
      `CHK(rdata_q, 16'h0000)
      // Result and status words must ignore writes
      for (int i = 4; i < 16; i++) begin
         if (i < 7 || i > 8) begin
            bus_wr(4'(i), 16'($random(seed)));
         end
      end
      sweep();
      bus_wr(`BWAU_OFS_IRQ_MSK, 16'h000F);
      m_msk = 4'hF;
      run_op(16'h0000, 16'h0000, BWAU_CLEAR_CARRY_OP, 1'b1, 1'b0);
      foreach (c_a[i]) begin
         run_op(16'h0000, 16'h0000, BWAU_CLEAR_CARRY_OP, 1'b1, 1'b0);
         run_op(c_a[i], c_b[i], c_op[i], 1'b1, 1'b0);
      end
      // Pointer limit, both sides of the boundary
      for (int i = 0; i < 2; i++) begin
         m_ptr = i ? 16'h2000 : 16'h1999;
         bus_wr(`BWAU_OFS_PTR, m_ptr);
         run_op(16'h8000, 16'h8000, BWAU_BINARY_ADD_OP, 1'b1, 1'b1);
      end
      for (int n = 0; n < 300; n++) begin
         r = $random(seed);
         if (r[0]) begin
            bus_wr(`BWAU_OFS_IRQ_ST, {12'h000, r[4:1]});
            m_ist &= ~r[4:1];
         end
         if (r[5]) begin
            bus_wr(`BWAU_OFS_IRQ_MSK, {12'h000, r[9:6]});
            m_msk = r[9:6];
         end
         m_ptr = r[10] ? 16'($random(seed)) : {3'b000, r[11], r[15:12] % 4'd10, r[19:16] % 4'd10, r[23:20] % 4'd10};
         bus_wr(`BWAU_OFS_PTR, m_ptr);
         run_op(16'($random(seed)), 16'($random(seed)), bwau_op_t'(r[31:29] % 3'd6), r[28:27] != 2'b00, r[26]);
      end
      // Second reset in mid-run
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      `CHK(irq_q, 1'b0)
      `CHK(rdata_q, 16'h0000)
      model_clear();
      sweep();
      test_done();
   end

   // Bound well above the expected run of about six thousand cycles
   initial begin
      repeat (40000) @(posedge mclk);
      errors++;
      test_done();
   end

endmodule : tb_top

`default_nettype wire
